// File: dv/apm_host_model.sv
// apm_host_model: host controller on the converter's data bus and frame sync pins.
// assumes the bench system clock; makes the 400 ns link clock itself in slave mode.
`default_nettype none

module apm_host_model (
  // clock
  input wire logic clk,
  // host straps and pacing
  input wire logic ext_sel,
  input wire logic sync_pol,
  input wire logic sclk_inv,
  input wire logic hold_clk,
  // device pins
  input wire logic [15:0] data_out,
  input wire logic [15:0] data_oe,
  input wire logic frame_sync_out,
  input wire logic frame_sync_oe,
  output logic [15:0] data_in,
  // received frames
  output logic [15:0] rx_word,
  output logic [7:0] rx_count,
  output var int frames
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [15:0] noise = 16'h5A5A;
  logic [15:0] shift_r = 16'h0000;
  logic [7:0] cnt = 8'h00;
  logic lclk = 1'b0;
  logic fa_q = 1'b0;
  logic ilclk_q = 1'b0;
  wire logic fa = frame_sync_oe & (frame_sync_out ^ sync_pol);
  wire logic ilclk = data_out[9] ^ sclk_inv;
  wire logic [15:0] drv = {noise[15:10], lclk ^ sclk_inv, noise[8:7], sclk_inv, sync_pol,
    ext_sel, noise[3:0]};

  // released pins other than the straps and the link clock pin see a changing pattern, never a held last value
  assign data_in = (data_oe & data_out) | (~data_oe & drv);

  initial frames = 0;

  always @(posedge clk) noise <= ~noise;

  // link clock only inside a frame; a held clock models a slow host
  initial begin
    #13;
    forever begin
      #200;
      if (ext_sel && !hold_clk && (fa || lclk)) lclk = ~lclk;
    end
  end

  task automatic take(input logic b);
    shift_r = {shift_r[14:0], b};
    cnt = cnt + 8'h01;
  endtask

  // sampled midway through the low phase: the device resyncs our clock first
  always @(negedge lclk) begin
    #100;
    if (fa) take(data_out[8]);
  end

  always @(posedge clk) begin
    if (!fa_q && fa) cnt = 8'h00;
    if (!ext_sel && fa && ilclk_q && !ilclk) take(data_out[8]);
    if (fa_q && !fa) begin
      rx_word <= shift_r;
      rx_count <= cnt;
      frames <= frames + 1;
    end
    fa_q <= fa;
    ilclk_q <= ilclk;
  end
endmodule // apm_host_model

`default_nettype wire

// File: dv/tb_top.sv
// tb_top: self-checking bench for the converter port and mode strap logic.
// assumes apm_pkg, the design files and apm_host_model are compiled first.
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import apm_pkg::*;

  localparam int GAP = 50;
  // about seven times the expected run
  localparam int TIMEOUT_NS = 20000 * 50;

  typedef struct packed {
    logic fast, low, coding, port, ext, pol, inv;
    logic [1:0] mode;
    logic [15:0] res;
  } apm_tb_row_t;

  localparam apm_tb_row_t ROWS [8] = '{
    '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 2'h1, 16'h8001},
    '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0, 16'h1234},
    '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 2'h2, 16'hFFFE},
    '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0, 16'h7F00},
    '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 2'h1, 16'hA5C3},
    '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 2'h0, 16'h0F0F},
    '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 2'h2, 16'h8000},
    '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 2'h1, 16'h3C5A}};

  logic clk = 1'b0;
  logic reset = 1'b1;
  logic output_coding_select = 1'b0, fast_mode_select = 1'b0;
  logic low_power_mode_select = 1'b0, port_type_select = 1'b0, conv_start_n = 1'b1;
  logic ext_sel = 1'b0, sync_pol = 1'b0, sclk_inv = 1'b0, hold_clk = 1'b0;
  logic [15:0] core_result = 16'h0000;
  logic [15:0] data_in, data_out, data_oe, rx_word, exp;
  logic busy, accuracy_warn, core_power_up, frame_sync_out, frame_sync_oe;
  logic [7:0] rx_count;
  apm_mode_t conv_mode;
  apm_tb_row_t row;
  int frames, f0, cyc;
  int err_total = 0;
  int compares = 0;

  apm_port_mode #(.MAX_GAP_CYCLES(GAP)) u_apm_port_mode (
    .clk(clk), .reset(reset), .output_coding_select(output_coding_select),
    .fast_mode_select(fast_mode_select), .low_power_mode_select(low_power_mode_select),
    .port_type_select(port_type_select), .conv_start_n(conv_start_n), .busy(busy),
    .accuracy_warn(accuracy_warn), .core_result(core_result),
    .core_power_up(core_power_up), .conv_mode(conv_mode), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe), .frame_sync_out(frame_sync_out),
    .frame_sync_oe(frame_sync_oe));

  apm_host_model u_apm_host_model (
    .clk(clk), .ext_sel(ext_sel), .sync_pol(sync_pol), .sclk_inv(sclk_inv),
    .hold_clk(hold_clk), .data_out(data_out), .data_oe(data_oe),
    .frame_sync_out(frame_sync_out), .frame_sync_oe(frame_sync_oe), .data_in(data_in),
    .rx_word(rx_word), .rx_count(rx_count), .frames(frames));

  initial begin
    forever #25 clk = ~clk;
  end

  task automatic tally_and_finish();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp_v, input logic [15:0] got);
    compares++;
    if (got !== exp_v) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", what, exp_v, got);
    end
  endtask

  task automatic set_straps(input logic f, l, c, p, e, s, v);
    @(negedge clk);
    {fast_mode_select, low_power_mode_select, output_coding_select, port_type_select} =
      {f, l, c, p};
    {ext_sel, sync_pol, sclk_inv} = {e, s, v};
    repeat (8) @(negedge clk);
  endtask

  // n counts busy cycles, capped at 60 so a stalled push shows as 60
  task automatic convert(input logic [15:0] res, output int n);
    core_result = res;
    conv_start_n = 1'b0;
    for (int i = 0; i < 10 && busy !== 1'b1; i++) @(negedge clk);
    conv_start_n = 1'b1;
    n = 0;
    while (busy === 1'b1 && n < 60) begin
      n++;
      @(negedge clk);
    end
  endtask

  task automatic wait_frame(input int fc);
    for (int i = 0; i < 600 && frames == fc; i++) @(negedge clk);
  endtask

  function automatic int conv_len(input logic [1:0] m);
    if (m == APM_MODE_FAST) return CONV_FAST_CYC + 1;
    if (m == APM_MODE_LOW_POWER) return CONV_LOW_CYC + 1;
    return CONV_NORMAL_CYC + 1;
  endfunction

  initial begin
    repeat (11) @(negedge clk);
    chk("oe_reset", 16'h000F, data_oe);
    chk("out_reset", 16'h0000, data_out);
    chk("idle_reset", 16'h0000, {14'h0000, busy, frame_sync_oe});
    @(negedge clk);
    reset = 1'b0;
    for (int r = 0; r < 8; r++) begin
      row = ROWS[r];
      set_straps(row.fast, row.low, row.coding, row.port, row.ext, row.pol, row.inv);
      chk("mode", {14'h0000, row.mode}, {14'h0000, conv_mode});
      chk("power_up", {15'h0000, row.mode != 2'h2}, {15'h0000, core_power_up});
      chk("oe_low", 16'h000F, data_oe & 16'h000F);
      if (row.port) begin
        chk("oe_serial", {6'h00, ~row.ext, 9'h000}, data_oe & 16'h0270);
        chk("sync_idle", {15'h0000, row.pol}, {15'h0000, frame_sync_out});
        chk("sync_oe", 16'h0001, {15'h0000, frame_sync_oe});
      end else begin
        chk("oe_par", 16'h0070, data_oe & 16'h0070);
      end
      f0 = frames;
      convert(row.res, cyc);
      chk("busy_len", 16'(conv_len(row.mode)), 16'(cyc));
      exp = row.coding ? row.res : row.res ^ 16'h8000;
      if (row.port) begin
        wait_frame(f0);
        chk("serial_word", exp, rx_word);
        chk("serial_bits", 16'h0010, {8'h00, rx_count});
      end else begin
        repeat (4) @(negedge clk);
        chk("par_word", exp, data_out);
      end
    end
    // second start inside a conversion is ignored
    set_straps(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    fork
      convert(16'h4321, cyc);
      begin
        repeat (12) @(negedge clk);
        conv_start_n = 1'b0;
        repeat (3) @(negedge clk);
        conv_start_n = 1'b1;
      end
    join
    chk("busy_len", 16'(CONV_FAST_CYC + 1), 16'(cyc));
    repeat (4) @(negedge clk);
    chk("par_word", 16'h4321, data_out);
    chk("warn_early", 16'h0000, {15'h0000, accuracy_warn});
    repeat (30) @(negedge clk);
    chk("warn_late", 16'h0001, {15'h0000, accuracy_warn});
    set_straps(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    repeat (GAP) @(negedge clk);
    chk("warn_normal", 16'h0000, {15'h0000, accuracy_warn});
    // host stalls its clock: one word in the frame, eight queued, one held back
    hold_clk = 1'b1;
    set_straps(1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
    f0 = frames;
    for (int k = 0; k < 10; k++) convert(16'h0100 + 16'(k), cyc);
    chk("stall_len", 16'h003C, 16'(cyc));
    chk("stall_busy", 16'h0001, {15'h0000, busy});
    @(negedge clk);
    hold_clk = 1'b0;
    for (int k = 0; k < 10; k++) begin
      wait_frame(f0 + k);
      chk("fifo_word", 16'h0100 + 16'(k), rx_word);
    end
    chk("drained_busy", 16'h0000, {15'h0000, busy});
    tally_and_finish();
  end

  initial begin
    #(TIMEOUT_NS);
    err_total++;
    tally_and_finish();
  end
endmodule // tb_top

`default_nettype wire

// File: rtl/apm_fifo.sv
// apm_fifo: flip-flop FIFO with valid/ready on both sides.
// assumes the same clock on both sides; depth a power of two.
`default_nettype none

module apm_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [AW:0] cnt_r;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  assign in_ready = (cnt_r < (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data = mem_r[rd_r];

  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wr_r] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) wr_r <= wr_r + 1'b1;
      if (pop) rd_r <= rd_r + 1'b1;
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // apm_fifo

`default_nettype wire

// File: rtl/apm_pkg.sv
// apm_pkg: constants and types for the converter port and mode strap logic.
// assumes a single 20 MHz system clock; all times are converted to cycles here.
`default_nettype none

package apm_pkg;
  localparam int WORD_W = 16;
  localparam int FIFO_DEPTH = 8;
  localparam int CLK_PERIOD_NS = 50;
  // conversion times, longest figures, rounded down to whole cycles
  localparam int T_CONV_FAST_NS = 1500;
  localparam int T_CONV_NORMAL_NS = 1750;
  localparam int T_CONV_LOW_NS = 2000;
  localparam int CONV_FAST_CYC = T_CONV_FAST_NS / CLK_PERIOD_NS;
  localparam int CONV_NORMAL_CYC = T_CONV_NORMAL_NS / CLK_PERIOD_NS;
  localparam int CONV_LOW_CYC = T_CONV_LOW_NS / CLK_PERIOD_NS;
  localparam int CONV_CNT_W = 6;
  // longest gap between starts in fast mode
  localparam int T_MAX_GAP_NS = 1000000;
  localparam int MAX_GAP_CYC = T_MAX_GAP_NS / CLK_PERIOD_NS;
  localparam int GAP_CNT_W = 16;
  // internal serial clock: half period in system cycles
  localparam int SCLK_HALF_CYC = 2;
  localparam int BIT_CNT_W = 5;
  // data bus pin positions
  localparam int LOW_OUT_BITS = 4;
  localparam int PIN_EXT_SEL = 4;
  localparam int PIN_SYNC_POL = 5;
  localparam int PIN_SCLK_INV = 6;
  localparam int PIN_SDO = 8;
  localparam int PIN_SCLK = 9;
  // reset values of pin drivers
  localparam logic [WORD_W-1:0] PIN_OE_RESET = 16'h000F;
  localparam logic [WORD_W-1:0] PIN_OUT_RESET = 16'h0000;

  typedef enum logic [1:0] {
    APM_MODE_NORMAL,
    APM_MODE_FAST,
    APM_MODE_LOW_POWER
  } apm_mode_t;

  typedef enum logic [1:0] {
    APM_ST_IDLE,
    APM_ST_CONV,
    APM_ST_PUSH
  } apm_conv_st_t;
endpackage : apm_pkg

`default_nettype wire

// File: rtl/apm_port_mode.sv
// apm_port_mode: strap-driven mode, coding and port selection for the
// converter's digital side, with the parallel and serial result paths.
// assumes straps and host clock arrive asynchronously and are synchronised
// here; the analog core presents its result word at the end of conversion.
`default_nettype none

module apm_port_mode #(
  parameter int MAX_GAP_CYCLES = apm_pkg::MAX_GAP_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // strap pins
  input wire logic output_coding_select,
  input wire logic fast_mode_select,
  input wire logic low_power_mode_select,
  input wire logic port_type_select,
  // conversion start pin and status
  input wire logic conv_start_n,
  output logic busy,
  output logic accuracy_warn,
  // analog core
  input wire logic [apm_pkg::WORD_W-1:0] core_result,
  output logic core_power_up,
  output apm_pkg::apm_mode_t conv_mode,
  // data bus pins
  input wire logic [apm_pkg::WORD_W-1:0] data_in,
  output logic [apm_pkg::WORD_W-1:0] data_out,
  output logic [apm_pkg::WORD_W-1:0] data_oe,
  // frame sync pin
  output logic frame_sync_out,
  output logic frame_sync_oe
);
  import apm_pkg::*;

  // pin synchronisers
  logic [8:0] sync_q;
  wire coding_s = sync_q[0];
  wire fast_s = sync_q[1];
  wire lowp_s = sync_q[2];
  wire serial_s = sync_q[3];
  wire ext_clk_s = sync_q[4];
  wire sync_pol_s = sync_q[5];
  wire sclk_inv_s = sync_q[6];
  wire sclk_pin_s = sync_q[7];
  // start pin rides the synchroniser inverted so its reset value reads as idle
  wire cnv_n_s = ~sync_q[8];

  apm_sync #(.W(9)) u_sync (
    .clk(clk),
    .reset(reset),
    .d({~conv_start_n, data_in[PIN_SCLK], data_in[PIN_SCLK_INV], data_in[PIN_SYNC_POL],
        data_in[PIN_EXT_SEL], port_type_select, low_power_mode_select,
        fast_mode_select, output_coding_select}),
    .q(sync_q)
  );

  function automatic logic [CONV_CNT_W-1:0] conv_cycles(input apm_mode_t m);
    unique case (m)
      APM_MODE_FAST: conv_cycles = CONV_CNT_W'(CONV_FAST_CYC);
      APM_MODE_LOW_POWER: conv_cycles = CONV_CNT_W'(CONV_LOW_CYC);
      APM_MODE_NORMAL: conv_cycles = CONV_CNT_W'(CONV_NORMAL_CYC);
    endcase
  endfunction

  function automatic logic [WORD_W-1:0] apply_coding(input logic [WORD_W-1:0] w,
                                                     input logic straight);
    apply_coding = {w[WORD_W-1] ^ ~straight, w[WORD_W-2:0]};
  endfunction

  // mode decode; both selects high is not a legal strap and falls to normal
  wire mode_fast = fast_s && !lowp_s;
  wire mode_low = lowp_s && !fast_s;
  assign conv_mode = mode_fast ? APM_MODE_FAST :
                     (mode_low ? APM_MODE_LOW_POWER : APM_MODE_NORMAL);

  // conversion sequencer
  apm_conv_st_t st_r;
  apm_conv_st_t st_nxt;
  logic [CONV_CNT_W-1:0] cnt_r;
  logic [CONV_CNT_W-1:0] cnt_nxt;
  logic [WORD_W-1:0] res_r;
  logic cnv_prev_r;
  logic fifo_in_ready;
  wire cnv_fall = cnv_prev_r && !cnv_n_s;
  wire push_valid = (st_r == APM_ST_PUSH);

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    unique case (st_r)
      APM_ST_IDLE: begin
        if (cnv_fall) begin
          st_nxt = APM_ST_CONV;
          cnt_nxt = conv_cycles(conv_mode) - 1'b1;
        end
      end
      APM_ST_CONV: begin
        if (cnt_r == '0) begin
          st_nxt = APM_ST_PUSH;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      APM_ST_PUSH: begin
        // a full FIFO holds the sequencer here and later starts are ignored
        if (fifo_in_ready) st_nxt = APM_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_r <= APM_ST_IDLE;
      cnt_r <= '0;
      cnv_prev_r <= 1'b1;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      cnv_prev_r <= cnv_n_s;
    end
  end

  always_ff @(posedge clk) begin
    if (st_r == APM_ST_CONV && cnt_r == '0) res_r <= core_result;
  end

  assign busy = (st_r != APM_ST_IDLE);
  // low power: the core only draws power around a conversion
  assign core_power_up = !mode_low || busy;

  // gap monitor: flags when fast mode starts come too far apart
  logic [GAP_CNT_W-1:0] gap_r;
  logic warn_r;
  wire gap_over = (gap_r >= GAP_CNT_W'(MAX_GAP_CYCLES));

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      gap_r <= '0;
      warn_r <= 1'b0;
    end else begin
      if (cnv_fall) gap_r <= '0;
      else if (!gap_over) gap_r <= gap_r + 1'b1;
      warn_r <= mode_fast && gap_over;
    end
  end
  assign accuracy_warn = warn_r;

  // result FIFO between the sequencer and the read ports
  logic fifo_out_valid;
  logic [WORD_W-1:0] fifo_out_data;
  logic frame_r;
  wire fifo_out_ready = serial_s ? !frame_r : 1'b1;
  wire pop = fifo_out_valid && fifo_out_ready;
  wire [WORD_W-1:0] coded = apply_coding(fifo_out_data, coding_s);

  apm_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .reset(reset),
    .in_valid(push_valid),
    .in_ready(fifo_in_ready),
    .in_data(res_r),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  // parallel word register
  logic [WORD_W-1:0] par_word_r;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) par_word_r <= '0;
    else if (pop && !serial_s) par_word_r <= coded;
  end

  // serial clock: internal divider or host clock, both seen as one logical clock
  logic [1:0] div_r;
  logic int_phase_r;
  logic lclk_prev_r;
  wire int_tick = frame_r && !ext_clk_s && (div_r == 2'(SCLK_HALF_CYC - 1));
  wire lclk = ext_clk_s ? (sclk_pin_s ^ sclk_inv_s) : int_phase_r;
  wire upd_ev = lclk && !lclk_prev_r;
  wire smp_ev = !lclk && lclk_prev_r;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      div_r <= '0;
      int_phase_r <= 1'b0;
      lclk_prev_r <= 1'b0;
    end else begin
      lclk_prev_r <= lclk;
      if (!frame_r || ext_clk_s) begin
        div_r <= '0;
        int_phase_r <= 1'b0;
      end else if (int_tick) begin
        div_r <= '0;
        int_phase_r <= !int_phase_r;
      end else begin
        div_r <= div_r + 1'b1;
      end
    end
  end

  // serial shifter; a frame ends on the sampling edge after the last bit
  logic [WORD_W-1:0] sr_r;
  logic [BIT_CNT_W-1:0] bit_r;
  logic sdo_r;
  wire bits_done = (bit_r == BIT_CNT_W'(WORD_W));
  wire shift_ev = frame_r && upd_ev && !bits_done;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      frame_r <= 1'b0;
      sr_r <= '0;
      bit_r <= '0;
      sdo_r <= 1'b0;
    end else if (pop && serial_s) begin
      frame_r <= 1'b1;
      sr_r <= coded;
      bit_r <= '0;
    end else if (shift_ev) begin
      sdo_r <= sr_r[WORD_W-1];
      sr_r <= {sr_r[WORD_W-2:0], 1'b0};
      bit_r <= bit_r + 1'b1;
    end else if (frame_r && smp_ev && bits_done) begin
      frame_r <= 1'b0;
    end
  end

  // pin drivers, registered so every data pin leaves a flip-flop
  logic [WORD_W-1:0] pin_out_nxt;
  logic [WORD_W-1:0] pin_oe_nxt;
  logic [WORD_W-1:0] pin_out_r;
  logic [WORD_W-1:0] pin_oe_r;
  logic fs_out_r;
  logic fs_oe_r;

  always_comb begin
    pin_out_nxt = par_word_r;
    pin_oe_nxt = '1;
    if (serial_s) begin
      pin_out_nxt[WORD_W-1:LOW_OUT_BITS] = '0;
      pin_oe_nxt[7:LOW_OUT_BITS] = '0;
      pin_out_nxt[PIN_SDO] = sdo_r;
      pin_out_nxt[PIN_SCLK] = int_phase_r ^ sclk_inv_s;
      pin_oe_nxt[PIN_SCLK] = !ext_clk_s;
    end
    pin_oe_nxt[LOW_OUT_BITS-1:0] = '1;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pin_out_r <= PIN_OUT_RESET;
      pin_oe_r <= PIN_OE_RESET;
      fs_out_r <= 1'b0;
      fs_oe_r <= 1'b0;
    end else begin
      pin_out_r <= pin_out_nxt;
      pin_oe_r <= pin_oe_nxt;
      fs_out_r <= frame_r ^ sync_pol_s;
      fs_oe_r <= serial_s;
    end
  end

  assign data_out = pin_out_r;
  assign data_oe = pin_oe_r;
  assign frame_sync_out = fs_out_r;
  assign frame_sync_oe = fs_oe_r;

  // checks
  sequence s_start(apm_mode_t m);
    st_r == APM_ST_IDLE && cnv_fall && conv_mode == m;
  endsequence

  sequence s_par_pop;
    pop && !serial_s;
  endsequence

  // copy of the word at frame start, so the bit order check does not lean on the shifter
  logic [WORD_W-1:0] frame_word_r;
  always_ff @(posedge clk) begin
    if (pop && serial_s) frame_word_r <= coded;
  end
  wire [3:0] bit_pos = 4'(WORD_W - 1) - bit_r[3:0];

  AST_STRAIGHT: assert property (@(posedge clk) disable iff (reset)
    s_par_pop ##0 coding_s |=> par_word_r == $past(fifo_out_data))
    else $error("straight binary word altered");
  AST_TWOS: assert property (@(posedge clk) disable iff (reset)
    s_par_pop ##0 !coding_s |=> par_word_r[15] != $past(fifo_out_data[15]))
    else $error("msb not inverted for two's complement");
  AST_FAST_CONV: assert property (@(posedge clk) disable iff (reset)
    s_start(APM_MODE_FAST) |=> (st_r == APM_ST_CONV)[*8] ##23 st_r == APM_ST_PUSH)
    else $error("fast conversion length wrong");
  AST_NORMAL_CONV: assert property (@(posedge clk) disable iff (reset)
    s_start(APM_MODE_NORMAL) |-> ##36 st_r == APM_ST_PUSH)
    else $error("normal conversion length wrong");
  AST_LOW_CONV: assert property (@(posedge clk) disable iff (reset)
    s_start(APM_MODE_LOW_POWER) |-> ##41 st_r == APM_ST_PUSH)
    else $error("low power conversion length wrong");
  AST_LOW_POWER_OFF: assert property (@(posedge clk) disable iff (reset)
    conv_mode == APM_MODE_LOW_POWER && !busy |-> !core_power_up)
    else $error("core powered while idle in low power mode");
  AST_NO_WARN: assert property (@(posedge clk) disable iff (reset)
    conv_mode != APM_MODE_FAST |=> !accuracy_warn)
    else $error("accuracy warning outside fast mode");
  AST_LOW_BITS: assert property (@(posedge clk) disable iff (reset)
    data_oe[3:0] == 4'hF)
    else $error("low bus bits not driven");
  AST_MID_BITS: assert property (@(posedge clk) disable iff (reset)
    $stable(serial_s) |=> data_oe[6:4] == {3{!$past(serial_s)}})
    else $error("bits 4 to 6 direction wrong");
  AST_SCLK_DRIVE: assert property (@(posedge clk) disable iff (reset)
    serial_s && !ext_clk_s |=> data_oe[PIN_SCLK] && data_out[PIN_SCLK]
      == $past(int_phase_r ^ sclk_inv_s))
    else $error("internal serial clock not driven");
  AST_FSYNC: assert property (@(posedge clk) disable iff (reset)
    ##1 frame_sync_out == ($past(frame_r) ^ $past(sync_pol_s)))
    else $error("frame sync polarity wrong");
  AST_MSB_FIRST: assert property (@(posedge clk) disable iff (reset)
    shift_ev |=> sdo_r == $past(frame_word_r[bit_pos]))
    else $error("serial bit order wrong");
endmodule // apm_port_mode

`default_nettype wire

// File: rtl/apm_sync.sv
// apm_sync: two-flop synchroniser for a vector of independent levels.
// assumes every bit is a slow level; no bit pairs with another.
`default_nettype none

module apm_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule // apm_sync

`default_nettype wire
